// ==== faack_fault_src.sv ====
// faack_fault_src: model of the fault detector ahead of the acknowledge unit.
// assumes one fault at a time, raised by the bench; hold keeps its cause present.
`default_nettype none
module faack_fault_src #(
  parameter int CAUSE_CYC = 5
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic raise, // new fault request
  input wire logic hold, // keep the cause present
  input wire logic fault_clear, // acknowledge from the unit
  output logic fault_event, // pulse on a new fault
  output logic fault_pending, // fault awaits acknowledgement
  output logic fault_cause_active // fault condition present
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc;
  ////////////////////////////////////////
  // the cause outlives the event a few cycles, as a real trip would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_event <= 1'b0;
      fault_pending <= 1'b0;
      fault_cause_active <= 1'b0;
      cyc <= 0;
    end else begin
      fault_event <= raise;
      if (cyc != 0) begin
        cyc <= cyc - 1;
      end
      if (raise) begin
        fault_pending <= 1'b1;
        cyc <= CAUSE_CYC;
      end else if (fault_clear) begin
        fault_pending <= 1'b0;
      end
      fault_cause_active <= raise | hold | (cyc > 1);
    end
  end
endmodule
`default_nettype wire

// ==== faack_pkg.sv ====
// faack_pkg: constants and state types of the fault auto-acknowledge unit.
// assumes one 50 MHz clock; settings arrive stable from parameter storage.
// Overview of operation
// [RQ1] delay setting zero disables auto acknowledge; nonzero is seconds, up to 1000.
// [RQ2] maximum-count setting zero means no limit on automatic acknowledgements.
// [RQ3] nonzero maximum count, up to 500, caps accepted automatic acknowledgements.
// [RQ4] counter clears after error-free running for maximum count times delay seconds.
// [RQ5] an attempt that would exceed the cap raises fault code 22 instead.
// [RQ6] the count-exceeded fault stays latched until power-on reset.
// [RQ7] acknowledgement only accepted once the fault cause has gone away.
// [RQ8] manual source: 0 none, 1-4 digital input rising edge, 5 keypad key.
// [RQ9] delay timer restarts on each new fault; counter adds one per auto acknowledge.
`default_nettype none
package faack_pkg;
  localparam int unsigned FAACK_SEC_NS = 1000000000;
  localparam int unsigned FAACK_CLK_NS = 20;
  localparam int unsigned FAACK_TICK_CYC = FAACK_SEC_NS / FAACK_CLK_NS;
  localparam logic [9:0] FAACK_DLY_MAX = 10'h3e8;
  localparam logic [9:0] FAACK_DLY_DEF = 10'h000;
  localparam logic [8:0] FAACK_CNT_MAX = 9'h1f4;
  localparam logic [8:0] FAACK_CNT_DEF = 9'h005;
  localparam logic [2:0] FAACK_SRC_NONE = 3'h0;
  localparam logic [2:0] FAACK_SRC_KEY = 3'h5;
  localparam logic [7:0] FAACK_CODE_LIMIT = 8'h16;
  localparam logic [7:0] FAACK_CODE_NONE = 8'h00;

  typedef enum logic [1:0] {
    FAACK_ST_IDLE = 2'b00,
    FAACK_ST_WAIT = 2'b01,
    FAACK_ST_LOCK = 2'b10
  } faack_st_e;

  typedef struct packed {
    faack_st_e st;
    logic [9:0] dly;
    logic [18:0] run;
    logic [8:0] cnt;
    logic clr;
    logic auto_ack;
    logic lock;
    logic [7:0] code;
    logic [3:0] din_m;
    logic [3:0] din_s;
    logic [3:0] din_p;
    logic key_m;
    logic key_s;
    logic key_p;
  } faack_state_s;
endpackage
`default_nettype wire

// ==== faack_sec_tick.sv ====
// faack_sec_tick: one-cycle pulse once per second from the system clock.
// assumes the count is the number of clock cycles in one second.
`default_nettype none
module faack_sec_tick #(
  parameter int unsigned TICK_CYC = 50000000
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  output logic tick // one-cycle pulse each second
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_d;

  always_comb begin
    tick_d = (cnt_q == 32'(TICK_CYC - 1));
    cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ==== faack_top.sv ====
// faack_top: automatic and manual fault acknowledgement with a count limit.
// assumes fault status and motor-running come from logic on the same clock;
// digital inputs and the keypad key are pins and are synchronised here.
`default_nettype none
module faack_top
  import faack_pkg::*;
#(
  parameter int unsigned TICK_CYC = FAACK_TICK_CYC
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst, // power-on reset, async, active high
  input wire logic fault_event, // pulse: a new fault was detected
  input wire logic fault_pending, // level: a fault awaits acknowledgement
  input wire logic fault_cause_active, // level: the fault condition is still present
  input wire logic motor_running, // level: motor current above 0.2 A
  input wire logic [3:0] din, // digital input pins
  input wire logic ack_key, // keypad acknowledge key pin
  input wire logic [9:0] ack_delay_s, // auto acknowledge delay in seconds, 0 = off
  input wire logic [8:0] ack_max, // auto acknowledge limit, 0 = unlimited
  input wire logic [2:0] ack_src, // manual acknowledge source code
  output logic fault_clear, // pulse: pending fault is acknowledged
  output logic auto_ack, // pulse: the acknowledgement was automatic
  output logic [8:0] ack_count, // automatic acknowledgements made
  output logic lock_fault, // latched count-exceeded fault
  output logic [7:0] fault_code // code of the latched fault, 0 if none
);

  ////////////////////////////////////////////////////////////////////////
  // seconds timebase

  logic sec_tick;

  faack_sec_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(sec_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // manual source selection

  function automatic logic faack_man_sel(input logic [2:0] src, input logic [3:0] edges,
                                         input logic key_edge);
    logic r;
    r = 1'b0;
    if (src == FAACK_SRC_KEY) begin
      r = key_edge;
    end else if (src != FAACK_SRC_NONE && src < FAACK_SRC_KEY) begin
      r = edges[src[1:0] - 2'h1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  faack_state_s q;
  faack_state_s d;
  logic [18:0] period;
  logic man_ack;
  logic ack_ok;
  logic dly_done;
  logic over_cap;

  always_comb begin
    d = q;
    d.clr = 1'b0;
    d.auto_ack = 1'b0;
    d.din_m = din;
    d.din_s = q.din_m;
    d.din_p = q.din_s;
    d.key_m = ack_key;
    d.key_s = q.key_m;
    d.key_p = q.key_s;
    // both factors widened before the product: 500 x 1000 needs all 19 bits
    period = 19'(ack_max) * 19'(ack_delay_s); // see [RQ4]
    man_ack = faack_man_sel(ack_src, q.din_s & ~q.din_p, q.key_s & ~q.key_p); // see [RQ8]
    ack_ok = fault_pending && !fault_cause_active; // see [RQ7]
    dly_done = (ack_delay_s != 10'h0) && (q.dly >= ack_delay_s); // see [RQ1]
    over_cap = (ack_max != 9'h0) && (q.cnt >= ack_max); // see [RQ2] [RQ3]
    // error-free run time; any pending fault or a stopped motor restarts it
    if (!motor_running || fault_pending) begin
      d.run = 19'h0;
    end else if (q.run >= period) begin
      d.cnt = 9'h0; // see [RQ4]
      d.run = 19'h0;
    end else if (sec_tick) begin
      d.run = q.run + 19'h1;
    end
    case (q.st)
      FAACK_ST_IDLE: begin
        d.dly = 10'h0;
        if (fault_pending) begin
          d.st = FAACK_ST_WAIT;
        end
      end
      FAACK_ST_WAIT: begin
        if (fault_event) begin
          d.dly = 10'h0; // see [RQ9]
        end else if (sec_tick && q.dly != FAACK_DLY_MAX) begin
          d.dly = q.dly + 10'h1;
        end
        if (!fault_pending) begin
          d.st = FAACK_ST_IDLE;
        end else if (ack_ok && dly_done && !fault_event) begin
          if (over_cap) begin
            // no acknowledge: the limit fault takes over for good
            d.st = FAACK_ST_LOCK; // see [RQ5]
            d.lock = 1'b1;
            d.code = FAACK_CODE_LIMIT;
          end else begin
            d.clr = 1'b1;
            d.auto_ack = 1'b1;
            d.st = FAACK_ST_IDLE;
            if (q.cnt != 9'h1ff) begin
              d.cnt = q.cnt + 9'h1; // see [RQ9]
            end
          end
        end else if (ack_ok && man_ack) begin
          d.clr = 1'b1; // see [RQ8]
          d.st = FAACK_ST_IDLE;
        end
      end
      FAACK_ST_LOCK: begin
        // only power-on reset leaves this state
        d.lock = 1'b1; // see [RQ6]
        d.code = FAACK_CODE_LIMIT;
      end
      default: begin
        d.st = FAACK_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{st: FAACK_ST_IDLE, code: FAACK_CODE_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign fault_clear = q.clr;
  assign auto_ack = q.auto_ack;
  assign ack_count = q.cnt;
  assign lock_fault = q.lock;
  assign fault_code = q.code;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_auto_off;
    auto_ack |-> $past(ack_delay_s) != 10'h0;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto ack with zero delay"); // see [RQ1]

  property p_no_limit;
    $rose(lock_fault) |-> $past(ack_max) != 9'h0;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("limit fault while unlimited"); // see [RQ2]

  property p_cap;
    auto_ack && $past(ack_max) != 9'h0 |-> ack_count <= $past(ack_max);
  endproperty
  a_cap: assert property (p_cap) else $error("auto ack beyond the cap"); // see [RQ3]

  property p_run_reset;
    motor_running && !fault_pending && q.run >= period |=> ack_count == 9'h0;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("counter not cleared"); // see [RQ4]

  property p_code22;
    $rose(lock_fault) |-> !fault_clear && fault_code == FAACK_CODE_LIMIT;
  endproperty
  a_code22: assert property (p_code22) else $error("limit fault wrong"); // see [RQ5]

  property p_latched;
    lock_fault |=> lock_fault && !fault_clear;
  endproperty
  a_latched: assert property (p_latched) else $error("limit fault released"); // see [RQ6]

  property p_cause_gone;
    fault_clear |-> !$past(fault_cause_active) && $past(fault_pending);
  endproperty
  a_cause_gone: assert property (p_cause_gone) else $error("ack while cause present"); // see [RQ7]

  property p_src_none;
    fault_clear && !auto_ack |-> $past(ack_src) != FAACK_SRC_NONE;
  endproperty
  a_src_none: assert property (p_src_none) else $error("manual ack with source none"); // see [RQ8]

  property p_inc;
    auto_ack |-> ack_count == $past(ack_count) + 9'h1 || $past(ack_count) == 9'h1ff;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step"); // see [RQ9]

  c_auto: cover property (auto_ack);
  c_manual: cover property (fault_clear && !auto_ack);
  c_lock: cover property ($rose(lock_fault));
  c_reset_cnt: cover property ($fell(ack_count != 9'h0));
endmodule
`default_nettype wire

// ==== test_faack_top.sv ====
// test_faack_top: self-checking bench of the fault acknowledge unit.
// assumes a one-second tick of 10 cycles so delays of seconds stay short.
`default_nettype none
module test_faack_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, raise = 0, hold = 0, motor_running = 0, ack_key = 0, g;
  logic [3:0] din = 4'h0;
  logic [9:0] ack_delay_s = 10'h000;
  logic [8:0] ack_max = 9'h005, ack_count;
  logic [2:0] ack_src = 3'h0;
  logic fault_event, fault_pending, fault_cause_active, fault_clear, auto_ack, lock_fault;
  logic [7:0] fault_code;
  int error_cnt = 0, n_checks = 0, clr_n = 0, n0, w;
  faack_top #(.TICK_CYC(10)) dut (.clk, .rst, .fault_event, .fault_pending,
    .fault_cause_active, .motor_running, .din, .ack_key, .ack_delay_s, .ack_max,
    .ack_src, .fault_clear, .auto_ack, .ack_count, .lock_fault, .fault_code);
  faack_fault_src src_m (.clk, .rst, .raise, .hold, .fault_clear, .fault_event,
    .fault_pending, .fault_cause_active);
  always #10 clk = ~clk;
  // counted on the falling edge, away from the rising launching edge, so the pulse is settled when seen
  always @(negedge clk) if (fault_clear === 1'b1) clr_n++;
  ////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask
  // raises one fault and waits a bounded time for its acknowledgement
  task automatic fault(input int lim, output logic got, output int n);
    got = 0;
    n = 0;
    @(negedge clk);
    raise = 1'b1;
    @(negedge clk);
    raise = 1'b0;
    while (!got && n < lim) begin
      @(negedge clk);
      n++;
      got = (fault_clear === 1'b1);
    end
  endtask
  task automatic t_auto();
    ack_delay_s = 10'h002;
    ack_max = 9'h002;
    for (int i = 1; i <= 5; i++) begin
      if (i == 3) begin
        motor_running = 1'b1;
        repeat (25) @(negedge clk);
        chk(ack_count, 9'h002);
        repeat (30) @(negedge clk);
        chk(ack_count, 9'h000);
        motor_running = 1'b0;
      end
      fault(40, g, w);
      chk(9'(g), 9'(i < 5));
      if (i < 5) begin
        // two whole seconds after the timer starts, tick phase free: 13 to 22 cycles
        chk(9'(w >= 13 && w <= 22), 9'h001);
        chk(9'(auto_ack), 9'h001);
        chk(ack_count, 9'((i - 1) % 2 + 1));
      end
    end
    chk(9'(lock_fault), 9'h001);
    chk(9'(fault_code), 9'h016);
    n0 = clr_n;
    ack_src = 3'h5;
    ack_key = 1'b1;
    repeat (10) @(negedge clk);
    chk(9'(clr_n - n0), 9'h000);
    chk(9'(lock_fault), 9'h001);
    ack_key = 1'b0;
    do_reset();
    chk(9'(lock_fault), 9'h000);
    chk(ack_count, 9'h000);
    chk(9'(fault_code), 9'h000);
    $display("auto acknowledge test done");
  endtask
  task automatic t_unlim();
    ack_delay_s = 10'h001;
    ack_max = 9'h000;
    for (int i = 1; i <= 3; i++) begin
      fault(30, g, w);
      chk(ack_count, 9'(i));
    end
    chk(9'(lock_fault), 9'h000);
    $display("unlimited count test done");
  endtask
  // codes 7 and 6 act as none and leave their fault for the next raise;
  // code 0 runs last: its fault is never cleared
  task automatic t_manual();
    ack_delay_s = 10'h000;
    for (int k = 7; k >= 0; k--) begin
      ack_src = 3'(k);
      hold = 1'b1;
      n0 = clr_n;
      fault(1, g, w);
      for (int p = 0; p < 2; p++) begin
        ack_key = (k == 5 || k == 0 || k > 5);
        din = (k == 0 || k > 5) ? 4'hf : (k == 5 ? 4'h0 : 4'(1 << (k - 1)));
        repeat (8) @(negedge clk);
        chk(9'(clr_n - n0), 9'(p == 1 && k != 0 && k < 6));
        din = 4'h0;
        ack_key = 1'b0;
        hold = 1'b0;
        repeat (10) @(negedge clk);
      end
    end
    $display("manual source test done");
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    do_reset();
    t_auto();
    t_unlim();
    do_reset();
    t_manual();
    finish_test();
  end
  // about 550 cycles are needed; a hang is cut well beyond that
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
